// ===== logic/pls_regs.sv
`default_nettype none
module pls_regs
    import pls_pkg::*;
#(
    parameter logic [5:0] MAX_WIDTH = WIDTH_X1,
    parameter logic [7:0] PORT_NUM = PORT_NUM_RST
)
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Straps and link partner state
    input wire logic i_reverse_strap,
    input wire logic i_hotplug_strap,
    input wire logic [5:0] i_neg_width,
    input wire logic i_training,
    input wire logic i_train_err,
    // AXI4-Lite slave
    input wire logic i_awvalid,
    input wire logic [AXI_AW-1:0] i_awaddr,
    output logic o_awready,
    input wire logic i_wvalid,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_wready,
    output logic o_bvalid,
    output logic [1:0] o_bresp,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic [AXI_AW-1:0] i_araddr,
    output logic o_arready,
    output logic o_rvalid,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_rready,
    // Link control settings
    output logic [1:0] o_aspm_ctrl,
    output logic o_link_disable,
    output logic o_retrain,
    output logic o_common_clock,
    output logic o_ext_sync,
    output logic o_reverse_mode
);
    typedef struct packed {
        logic awready;
        logic [AXI_AW-1:0] awaddr;
        logic wready;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] aspm;
        logic ldis;
        logic retrain;
        logic cc;
        logic es;
        logic rev;
    } pls_regs_t;
    pls_regs_t st, next_st;

    logic strap_rev;
    logic strap_hp;
    logic strap_valid;
    logic [5:0] mon_width;
    logic mon_training;
    logic mon_terr;
    logic hp_en;
    logic wr_go;
    logic rd_take;

    // Straps taken after reset release
    pls_strap_cap u_strap (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_reverse_strap(i_reverse_strap),
        .i_hotplug_strap(i_hotplug_strap),
        .o_reverse(strap_rev),
        .o_hotplug(strap_hp),
        .o_valid(strap_valid)
    );

    // Link partner status snapshot
    pls_link_mon u_mon (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_neg_width(i_neg_width),
        .i_training(i_training),
        .i_train_err(i_train_err),
        .o_neg_width(mon_width),
        .o_training(mon_training),
        .o_train_err(mon_terr)
    );

    // Hot-plug only counts in reverse mode
    assign hp_en = strap_hp & strap_rev & strap_valid; // [RL8]

    // Word-aligned address match
    function automatic logic is_reg(input logic [AXI_AW-1:0] a,
                                    input logic [AXI_AW-1:0] off);
        return {a[AXI_AW-1:2], 2'b00} == off;
    endfunction

    function automatic logic mapped(input logic [AXI_AW-1:0] a);
        return is_reg(a, OFF_LINK_CAP) | is_reg(a, OFF_LINK_CTRL) |
               is_reg(a, OFF_SLOT_CAP);
    endfunction

    // Read word assembly, unlisted bits stay zero
    function automatic logic [31:0] rd_word(input logic [AXI_AW-1:0] a);
        logic [31:0] w;
        w = '0; // [RL9]
        if (is_reg(a, OFF_LINK_CAP)) begin
            w[CAP_SPEED_LSB +: 4] = SPEED_2G5; // [RL1]
            w[CAP_WIDTH_LSB +: 6] = MAX_WIDTH; // [RL2]
            w[CAP_ASPM_LSB +: 2] = ASPM_SUP_BOTH; // [RL3]
            w[CAP_L0S_LSB +: 3] = L0S_EXIT_LAT;
            w[CAP_L1_LSB +: 3] = L1_EXIT_LAT;
            w[CAP_PORT_LSB +: 8] = PORT_NUM;
        end else if (is_reg(a, OFF_LINK_CTRL)) begin
            w[CTRL_ASPM_LSB +: 2] = st.aspm;
            w[CTRL_RCB_BIT] = 1'b0; // [RL5]
            w[CTRL_DIS_BIT] = st.ldis;
            w[CTRL_RETRAIN_BIT] = st.retrain;
            w[CTRL_CC_BIT] = st.cc;
            w[CTRL_ES_BIT] = st.es;
            w[STS_SPEED_LSB +: 4] = SPEED_2G5; // [RL7]
            w[STS_WIDTH_LSB +: 6] = mon_width;
            w[STS_TERR_BIT] = mon_terr;
            w[STS_TRAIN_BIT] = mon_training;
            w[STS_SCC_BIT] = SLOT_CLK_CFG;
        end else if (is_reg(a, OFF_SLOT_CAP)) begin
            w[SLOT_ATTN_BTN_BIT] = hp_en; // [RL8]
            w[SLOT_PWR_CTL_BIT] = 1'b0;
            w[SLOT_MRL_BIT] = hp_en;
            w[SLOT_ATTN_IND_BIT] = hp_en;
            w[SLOT_PWR_IND_BIT] = hp_en;
            w[SLOT_HP_CAP_BIT] = hp_en;
        end
        return w;
    endfunction

    // Both write halves held and no response pending
    assign wr_go = !st.awready && !st.wready && !st.bvalid;
    assign rd_take = i_arvalid && st.arready;

    // Bus handshakes and register updates
    always_comb begin
        next_st = st;
        next_st.rev = strap_rev;
        // Write address and data, taken in either order
        if (i_awvalid && st.awready) begin
            next_st.awready = 1'b0;
            next_st.awaddr = i_awaddr;
        end
        if (i_wvalid && st.wready) begin
            next_st.wready = 1'b0;
            next_st.wdata = i_wdata[7:0];
            next_st.wstrb0 = i_wstrb[0];
        end
        // Commit the write once both halves are held
        if (wr_go) begin
            next_st.bvalid = 1'b1;
            next_st.bresp = mapped(st.awaddr) ? RESP_OKAY : RESP_SLVERR;
            // Only link control holds writable bits
            if (is_reg(st.awaddr, OFF_LINK_CTRL) && st.wstrb0) begin // [RL9]
                next_st.aspm = st.wdata[CTRL_ASPM_LSB +: 2]; // [RL4]
                next_st.cc = st.wdata[CTRL_CC_BIT];
                next_st.es = st.wdata[CTRL_ES_BIT];
                if (strap_rev) begin // [RL6]
                    next_st.ldis = st.wdata[CTRL_DIS_BIT];
                    next_st.retrain = st.wdata[CTRL_RETRAIN_BIT];
                end
            end
        end
        // Write response retires, slave ready again
        if (st.bvalid && i_bready) begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end
        // Read: data snapshot at address acceptance
        if (rd_take) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_word(i_araddr);
            next_st.rresp = mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (st.rvalid && i_rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
    end

    // State register with reset values
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.aspm <= ASPM_CTRL_RST; // [RL4]
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign o_awready = st.awready;
    assign o_wready = st.wready;
    assign o_bvalid = st.bvalid;
    assign o_bresp = st.bresp;
    assign o_arready = st.arready;
    assign o_rvalid = st.rvalid;
    assign o_rdata = st.rdata;
    assign o_rresp = st.rresp;
    assign o_aspm_ctrl = st.aspm;
    assign o_link_disable = st.ldis;
    assign o_retrain = st.retrain;
    assign o_common_clock = st.cc;
    assign o_ext_sync = st.es;
    assign o_reverse_mode = st.rev;

    // Checks on register behaviour
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    logic [1:0] w_aspm;
    logic w_dis;
    logic w_rt;
    assign w_aspm = st.wdata[CTRL_ASPM_LSB +: 2];
    assign w_dis = st.wdata[CTRL_DIS_BIT];
    assign w_rt = st.wdata[CTRL_RETRAIN_BIT];

    sequence rd_cap_s;
        rd_take && is_reg(i_araddr, OFF_LINK_CAP);
    endsequence

    sequence rd_ctrl_s;
        rd_take && is_reg(i_araddr, OFF_LINK_CTRL);
    endsequence

    sequence rd_slot_s;
        rd_take && is_reg(i_araddr, OFF_SLOT_CAP);
    endsequence

    sequence wr_ctrl_s;
        wr_go && is_reg(st.awaddr, OFF_LINK_CTRL) && st.wstrb0;
    endsequence

    cap_speed_a: assert property (rd_cap_s |=> o_rvalid && // [RL1]
        o_rdata[CAP_SPEED_LSB +: 4] == SPEED_2G5 && o_rresp == RESP_OKAY)
        else $error("max link speed field wrong");

    cap_width_a: assert property (rd_cap_s |=> // [RL2]
        o_rdata[CAP_WIDTH_LSB +: 6] == MAX_WIDTH)
        else $error("max link width field wrong");

    cap_aspm_a: assert property (rd_cap_s |=> // [RL3]
        o_rdata[CAP_ASPM_LSB +: 2] == ASPM_SUP_BOTH)
        else $error("aspm support field wrong");

    aspm_write_a: assert property (wr_ctrl_s |=> // [RL4]
        o_aspm_ctrl == $past(w_aspm) && o_bvalid)
        else $error("aspm control did not take write");

    aspm_hold_a: assert property (!wr_go |=> $stable(o_aspm_ctrl)) // [RL4]
        else $error("aspm control changed without write");

    rcb_zero_a: assert property (rd_ctrl_s |=> // [RL5]
        !o_rdata[CTRL_RCB_BIT] && o_rdata[CTRL_ASPM_LSB +: 2] == $past(st.aspm))
        else $error("rcb bit not zero");

    fwd_lock_a: assert property ((wr_ctrl_s and !strap_rev) |=> // [RL6]
        $stable(o_link_disable) && $stable(o_retrain))
        else $error("link disable or retrain written in forward mode");

    rev_write_a: assert property ((wr_ctrl_s and strap_rev) |=> // [RL6]
        o_link_disable == $past(w_dis) && o_retrain == $past(w_rt))
        else $error("link disable or retrain not written in reverse mode");

    sts_speed_a: assert property (rd_ctrl_s |=> // [RL7]
        o_rdata[STS_SPEED_LSB +: 4] == SPEED_2G5)
        else $error("link status speed wrong");

    slot_hp_a: assert property (rd_slot_s |=> // [RL8]
        o_rdata[SLOT_HP_CAP_BIT] == $past(hp_en) &&
        o_rdata[SLOT_ATTN_BTN_BIT] == $past(hp_en) && !o_rdata[SLOT_PWR_CTL_BIT])
        else $error("slot hot-plug bits wrong");

    resv_zero_a: assert property (rd_cap_s |=> o_rdata[23:18] == 6'h00) // [RL9]
        else $error("reserved capability bits not zero");

    unmapped_rd_a: assert property (rd_take && !mapped(i_araddr) |=> // [RL9]
        o_rdata == 32'h0000_0000 && o_rresp == RESP_SLVERR)
        else $error("unmapped read answer wrong");
endmodule : pls_regs
`default_nettype wire

// ===== common/pls_pkg.sv
// Summary of operation
// RL1: The link capability word reports a fixed maximum link speed code of 2.5 Gb/s in bits 3:0.
// RL2: The link capability word reports the maximum link width in bits 9:4, resetting to x1.
// RL3: The link capability word advertises ASPM support in bits 11:10 as both L0s and L1.
// RL4: The ASPM control field in link control bits 1:0 is writable and resets to disabled.
// RL5: The read completion boundary bit 3 of link control always reads zero.
// RL6: Link disable and retrain are read-only in forward mode, writable in reverse mode.
// RL7: The link status speed field in bits 19:16 reports the 2.5 Gb/s code.
// RL8: The slot hot-plug capability bits are one only with hot-plug strapped on in reverse mode.
// RL9: Reserved bits read as zero and writes to read-only fields are ignored.
`default_nettype none
package pls_pkg;
    // Register bus
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFF_LINK_CAP = 8'hbc;
    localparam logic [7:0] OFF_LINK_CTRL = 8'hc0;
    localparam logic [7:0] OFF_SLOT_CAP = 8'hc4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Fixed values and reset values
    localparam logic [3:0] SPEED_2G5 = 4'h1;
    localparam logic [5:0] WIDTH_X1 = 6'h01;
    localparam logic [1:0] ASPM_SUP_BOTH = 2'h3;
    localparam logic [1:0] ASPM_CTRL_RST = 2'h0;
    localparam logic [2:0] L0S_EXIT_LAT = 3'h3;
    localparam logic [2:0] L1_EXIT_LAT = 3'h0;
    localparam logic [7:0] PORT_NUM_RST = 8'h00;
    localparam logic SLOT_CLK_CFG = 1'h1;
    // Link capability field positions
    localparam int CAP_SPEED_LSB = 0;
    localparam int CAP_WIDTH_LSB = 4;
    localparam int CAP_ASPM_LSB = 10;
    localparam int CAP_L0S_LSB = 12;
    localparam int CAP_L1_LSB = 15;
    localparam int CAP_PORT_LSB = 24;
    // Link control and status field positions
    localparam int CTRL_ASPM_LSB = 0;
    localparam int CTRL_RCB_BIT = 3;
    localparam int CTRL_DIS_BIT = 4;
    localparam int CTRL_RETRAIN_BIT = 5;
    localparam int CTRL_CC_BIT = 6;
    localparam int CTRL_ES_BIT = 7;
    localparam int STS_SPEED_LSB = 16;
    localparam int STS_WIDTH_LSB = 20;
    localparam int STS_TERR_BIT = 26;
    localparam int STS_TRAIN_BIT = 27;
    localparam int STS_SCC_BIT = 28;
    // Slot capability field positions
    localparam int SLOT_ATTN_BTN_BIT = 0;
    localparam int SLOT_PWR_CTL_BIT = 1;
    localparam int SLOT_MRL_BIT = 2;
    localparam int SLOT_ATTN_IND_BIT = 3;
    localparam int SLOT_PWR_IND_BIT = 4;
    localparam int SLOT_HP_CAP_BIT = 6;
endpackage : pls_pkg
`default_nettype wire

// ===== logic/pls_strap_cap.sv
`default_nettype none
module pls_strap_cap
    import pls_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_reverse_strap,
    input wire logic i_hotplug_strap,
    output logic o_reverse,
    output logic o_hotplug,
    output logic o_valid
);
    typedef struct packed {
        logic valid;
        logic reverse;
        logic hotplug;
    } pls_strap_t;
    pls_strap_t st, next_st;

    // Capture straps once, on the first edge after reset release
    always_comb begin
        next_st = st;
        if (!st.valid) begin
            next_st.valid = 1'b1;
            next_st.reverse = i_reverse_strap;
            next_st.hotplug = i_hotplug_strap;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_reverse = st.reverse;
    assign o_hotplug = st.hotplug;
    assign o_valid = st.valid;
endmodule : pls_strap_cap
`default_nettype wire

// ===== logic/pls_link_mon.sv
`default_nettype none
module pls_link_mon
    import pls_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [5:0] i_neg_width,
    input wire logic i_training,
    input wire logic i_train_err,
    output logic [5:0] o_neg_width,
    output logic o_training,
    output logic o_train_err
);
    typedef struct packed {
        logic [5:0] width;
        logic training;
        logic train_err;
    } pls_mon_t;
    pls_mon_t st, next_st;

    // Sample the link partner state each cycle
    always_comb begin
        next_st.width = i_neg_width;
        next_st.training = i_training;
        next_st.train_err = i_train_err;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st <= '{width: WIDTH_X1, training: 1'b0, train_err: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign o_neg_width = st.width;
    assign o_training = st.training;
    assign o_train_err = st.train_err;
endmodule : pls_link_mon
`default_nettype wire

// ===== tb/pls_link_partner.sv
`default_nettype none
module pls_link_partner (
    input wire logic i_core_clk,
    input wire logic i_step,
    output logic [5:0] o_neg_width,
    output logic o_training,
    output logic o_train_err
);
    timeunit 1ns;
    timeprecision 1ns;

    // Only the legal width codes; zero is reserved
    logic [5:0] widths [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20};

    initial begin
        o_neg_width = 6'h01;
        o_training = 1'b0;
        o_train_err = 1'b0;
    end

    // New link state only on request, so the bench knows what is shown
    always @(posedge i_core_clk) begin
        if (i_step) begin
            o_neg_width <= widths[$urandom_range(0, 6)];
            o_training <= 1'($urandom);
            o_train_err <= 1'($urandom);
        end
    end
endmodule // pls_link_partner
`default_nettype wire

// ===== tb/pls_regs_test.sv
`default_nettype none
module pls_regs_test
    import pls_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst, rev, hp, step, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rd, d;
    logic [3:0] wstrb, s;
    logic [1:0] rs;
    logic [15:0] ctl;
    logic [5:0] p_width;
    logic p_tr, p_te;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp, o_aspm_ctrl;
    logic [31:0] o_rdata;
    logic o_link_disable, o_retrain, o_common_clock, o_ext_sync, o_reverse_mode;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;

    pls_regs u_pls_regs (.i_core_clk(clk), .i_rst(rst), .i_reverse_strap(rev),
        .i_hotplug_strap(hp), .i_neg_width(p_width), .i_training(p_tr), .i_train_err(p_te),
        .i_awvalid(awvalid), .i_awaddr(awaddr), .o_awready(o_awready), .i_wvalid(wvalid),
        .i_wdata(wdata), .i_wstrb(wstrb), .o_wready(o_wready), .o_bvalid(o_bvalid),
        .o_bresp(o_bresp), .i_bready(bready), .i_arvalid(arvalid), .i_araddr(araddr),
        .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .i_rready(rready), .o_aspm_ctrl(o_aspm_ctrl), .o_link_disable(o_link_disable),
        .o_retrain(o_retrain), .o_common_clock(o_common_clock), .o_ext_sync(o_ext_sync),
        .o_reverse_mode(o_reverse_mode));

    pls_link_partner u_pls_link_partner (.i_core_clk(clk), .i_step(step),
        .o_neg_width(p_width), .o_training(p_tr), .o_train_err(p_te));

    // 10 MHz clock
    always #50 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic conclude();
        $display("mismatches %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Expected link status half word
    function automatic logic [15:0] sts(input logic [5:0] w, input logic tr, input logic te);
        return {3'h0, SLOT_CLK_CFG, tr, te, w, SPEED_2G5};
    endfunction

    // Expected link capability word from the fixed field values
    function automatic logic [31:0] cap_word();
        return {PORT_NUM_RST, 6'h0, L1_EXIT_LAT, L0S_EXIT_LAT,
                ASPM_SUP_BOTH, WIDTH_X1, SPEED_2G5};
    endfunction

    // Write cycle: address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st,
                          output logic [1:0] r);
        logic aw_open;
        logic w_open;
        aw_open = 1'b1;
        w_open = 1'b1;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= v;
        wstrb <= st;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (aw_open && o_awready) begin
                awvalid <= 1'b0;
                aw_open = 1'b0;
            end
            if (w_open && o_wready) begin
                wvalid <= 1'b0;
                w_open = 1'b0;
            end
            if (o_bvalid) begin
                r = o_bresp;
                bready <= 1'b0;
                break;
            end
        end
        // Idle edge so a following call never reassigns bready in this step
        @(posedge clk);
    endtask

    // Read cycle: rready held until the data is seen
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic ar_open;
        ar_open = 1'b1;
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (ar_open && o_arready) begin
                arvalid <= 1'b0;
                ar_open = 1'b0;
            end
            if (o_rvalid) begin
                v = o_rdata;
                r = o_rresp;
                rready <= 1'b0;
                break;
            end
        end
        // Idle edge so a following call never reassigns rready in this step
        @(posedge clk);
    endtask

    // Straps settle during reset and are held through capture
    task automatic do_reset(input logic r, input logic h);
        rev <= r;
        hp <= h;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Main sequence: every strap combination, then register traffic
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {rev, hp, step, awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        void'($urandom(32'hd492));
        for (int k = 0; k < 4; k++) begin
            do_reset(k[1], k[0]);
            chk("reverse_mode", {31'h0, o_reverse_mode}, {31'h0, rev});
            axi_rd(OFF_LINK_CAP, rd, rs);
            chk("link_cap", rd, cap_word());
            axi_wr(OFF_LINK_CAP, $urandom, 4'hf, rs);
            chk("cap_wr_resp", {30'h0, rs}, {30'h0, RESP_OKAY});
            axi_rd(OFF_LINK_CAP, d, rs);
            chk("cap_after_wr", d, rd);
            axi_rd(OFF_SLOT_CAP, rd, rs);
            chk("slot_cap", rd, (rev && hp) ? 32'h0000005d : 32'h0);
            ctl = 16'h0;
            // ASPM codes 0..3, then random data, then a write with lane 0 off
            for (int j = 0; j < 6; j++) begin
                d = $urandom;
                if (j < 4) d[1:0] = j[1:0];
                s = (j == 5) ? 4'he : 4'hf;
                step <= 1'b1;
                @(posedge clk);
                step <= 1'b0;
                repeat (2) @(posedge clk);
                axi_wr(OFF_LINK_CTRL, d, s, rs);
                if (s[0]) ctl = d[15:0] & (rev ? 16'h00f3 : 16'h00c3);
                rd = {24'h0, o_ext_sync, o_common_clock, o_retrain, o_link_disable,
                      2'h0, o_aspm_ctrl};
                chk("ctrl_pins", rd, {16'h0, ctl});
                axi_rd(OFF_LINK_CTRL, rd, rs);
                chk("ctrl_status", rd, {sts(p_width, p_tr, p_te), ctl});
                chk("ctrl_rresp", {30'h0, rs}, {30'h0, RESP_OKAY});
            end
            // Unmapped word: error answer, zero data, no side effect
            axi_rd(8'hc8, rd, rs);
            chk("unmapped_rd", rd, 32'h0000_0000);
            chk("unmapped_rresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
            axi_wr(8'h10, $urandom, 4'hf, rs);
            chk("unmapped_wr", {30'h0, rs}, {30'h0, RESP_SLVERR});
            axi_rd(OFF_LINK_CTRL, rd, rs);
            chk("ctrl_kept", {16'h0, rd[15:0]}, {16'h0, ctl});
        end
        conclude();
    end
endmodule // pls_regs_test
`default_nettype wire
